//--- rtl/scl_top.sv
// System control latches: processor swap, memory control and timer status
//
// What this block does
// - Writing swap latch bit 7 selects processor: 1 the 16-bit, 0 the 8-bit.
// - The swap latch answers at I/O port FE.
// - Swap bit 1: 0 resume, 1 force an interrupt to the new processor.
// - Swap bit 0 set: 8-bit gets none, 16-bit gets all, swapping in.
// - Swap bit 0 clear: interrupts go to the selected processor.
// - Memory control at port FC; bits 3,2 pick the ROM option.
// - ROM option 0 at reset: every read is ROM, writes go to RAM.
// - ROM option 1 puts ROM at the top of every 64K page.
// - ROM option 2 puts ROM only at the top of the first megabyte.
// - ROM option 3 never selects the ROM.
// - A ROM access deselects all memory except video RAM.
// - RAM map bits 1,0; value 0 at reset gives contiguous 0 to 192K.
// - RAM map 1 swaps 0-48K with 64-112K.
// - RAM map 2 swaps 0-48K with 112-160K.
// - RAM map 3 swaps 4-60K with 68-124K.
// - Memory control bit 5 at 0 disables parity checking.
// - Writing bit 5 as 0 then 1 clears a latched parity error.
// - Channels 0 and 2 tick at 250 kHz; channel 1 from channel 0 output.
// - Timer interrupt is channel 0 output OR channel 2 output.
// - Timer status bit 0 records channel 0, bit 1 channel 2, readable.
// - Writing 0 to a timer status bit clears only that bit.
`timescale 1ns/1ps
module scl_top (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // I/O port cycles from the active processor
    input wire logic [7:0] ioAddr,
    input wire logic ioWr,
    input wire logic ioRd,
    input wire logic [7:0] ioWrData,
    output logic [7:0] ioRdData,
    // Memory cycles and decoded selects
    input wire scl_pkg::scl_mem_req_s memReq,
    output scl_pkg::scl_mem_sel_s memSel,
    // Processor selection and interrupt routing
    input wire logic irqReq,
    output logic sel16,
    output logic int8,
    output logic int16,
    // Parity control
    input wire logic parityErrIn,
    output logic zeroParity,
    output logic parityCheckEn,
    output logic parityErr,
    // Timer channel ticks and outputs
    input wire logic chan0_output,
    input wire logic chan2_output,
    output logic chan0_tick,
    output logic chan1_tick,
    output logic chan2_tick,
    output logic timerIrq
);
    import scl_pkg::*;

    // Pin synchronisers; the first stage only feeds the second
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [3:0] syncIn;
    logic irqS;
    logic perrS;
    logic out0S;
    logic out2S;

    assign syncIn = {chan2_output, chan0_output, parityErrIn, irqReq};
    assign irqS = sync2_q[0];
    assign perrS = sync2_q[1];
    assign out0S = sync2_q[2];
    assign out2S = sync2_q[3];

    always_ff @(posedge clock) begin
        if (reset) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else begin
            sync1_q <= syncIn;
            sync2_q <= sync1_q;
        end
    end

    // Port decode
    logic wrSwap;
    logic wrMem;
    logic wrTstat;
    assign wrSwap = ioWr && (ioAddr == SWAP_PORT);
    assign wrMem = ioWr && (ioAddr == MEM_CTL_PORT);
    assign wrTstat = ioWr && (ioAddr == TMR_STAT_PORT);

    // Swap latch and interrupt steering state
    logic sel16_q, sel16_d;
    logic maskMode_q, maskMode_d;
    logic forceInt_q, forceInt_d;
    logic swapIntPend_q, swapIntPend_d;
    logic irqPrev_q, irqPrev_d;
    logic int8_q, int8_d;
    logic int16_q, int16_d;

    // Only bits 7, 1 and 0 are kept; the rest of the byte is dropped
    always_comb begin
        sel16_d = sel16_q;
        maskMode_d = maskMode_q;
        forceInt_d = forceInt_q;
        swapIntPend_d = 1'b0;
        irqPrev_d = irqS;
        if (wrSwap) begin
            sel16_d = ioWrData[SWAP_SEL16_BIT];
            maskMode_d = ioWrData[SWAP_MASK_BIT];
            forceInt_d = ioWrData[SWAP_FORCE_INT_BIT];
            // A real change of processor with bit 1 set gets a forced interrupt
            swapIntPend_d = ioWrData[SWAP_FORCE_INT_BIT]
                            && (ioWrData[SWAP_SEL16_BIT] != sel16_q);
        end else if (maskMode_q && irqS && !irqPrev_q && !sel16_q) begin
            sel16_d = 1'b1;
        end
    end

    // Interrupt delivery follows the registered processor select; with swap bit 0 set all go to the 16-bit
    always_comb begin
        if (maskMode_q) begin
            int8_d = 1'b0;
            int16_d = irqS || (swapIntPend_q && sel16_q);
        end else begin
            int8_d = (irqS || swapIntPend_q) && !sel16_q;
            int16_d = (irqS || swapIntPend_q) && sel16_q;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            sel16_q <= SWAP_RESET[SWAP_SEL16_BIT];
            maskMode_q <= SWAP_RESET[SWAP_MASK_BIT];
            forceInt_q <= SWAP_RESET[SWAP_FORCE_INT_BIT];
            swapIntPend_q <= 1'b0;
            irqPrev_q <= 1'b0;
            int8_q <= 1'b0;
            int16_q <= 1'b0;
        end else begin
            sel16_q <= sel16_d;
            maskMode_q <= maskMode_d;
            forceInt_q <= forceInt_d;
            swapIntPend_q <= swapIntPend_d;
            irqPrev_q <= irqPrev_d;
            int8_q <= int8_d;
            int16_q <= int16_d;
        end
    end

    // Memory control latch and parity error state
    logic [7:0] memory_control_latch_q, memory_control_latch_d;
    logic parityErr_q, parityErr_d;

    // The error clear on a 0-then-1 of bit 5 wins over a new error that cycle
    always_comb begin
        memory_control_latch_d = memory_control_latch_q;
        parityErr_d = parityErr_q;
        if (perrS && memory_control_latch_q[PAR_CHECK_BIT]) begin
            parityErr_d = 1'b1;
        end
        if (wrMem) begin
            memory_control_latch_d = ioWrData;
            if (!memory_control_latch_q[PAR_CHECK_BIT] && ioWrData[PAR_CHECK_BIT]) begin
                parityErr_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            memory_control_latch_q <= MEM_CTL_RESET;
            parityErr_q <= 1'b0;
        end else begin
            memory_control_latch_q <= memory_control_latch_d;
            parityErr_q <= parityErr_d;
        end
    end

    // Address decode from the current options, registered to the selects
    scl_mem_sel_s selNext;
    scl_mem_sel_s memSel_q;
    scl_addr_map uMap (
        .req(memReq),
        .romOpt(memory_control_latch_q[ROM_OPT_HI_BIT:ROM_OPT_LO_BIT]),
        .ramMap(memory_control_latch_q[RAM_MAP_HI_BIT:RAM_MAP_LO_BIT]),
        .sel(selNext)
    );

    always_ff @(posedge clock) begin
        if (reset) begin
            memSel_q <= '0;
        end else begin
            memSel_q <= selNext;
        end
    end

    // Timer tick divider, one enable pulse per 4 us
    logic [7:0] tickCnt_q, tickCnt_d;
    logic tick_q, tick_d;
    logic chan1Tick_q, chan1Tick_d;
    always_comb begin
        tick_d = (tickCnt_q == TICK_LAST);
        tickCnt_d = tick_d ? 8'h00 : 8'(tickCnt_q + 8'h01);
        chan1Tick_d = out0S;
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            tickCnt_q <= 8'h00;
            tick_q <= 1'b0;
            chan1Tick_q <= 1'b0;
        end else begin
            tickCnt_q <= tickCnt_d;
            tick_q <= tick_d;
            chan1Tick_q <= chan1Tick_d;
        end
    end

    // Timer status: edge sets win over a same-cycle software clear
    logic [1:0] tstat_q, tstat_d;
    logic [1:0] outPrev_q;
    logic [1:0] outNow;
    logic timerIrq_q;
    assign outNow = {out2S, out0S};

    for (genvar i = 0; i < 2; i++) begin : gStat
        always_comb begin
            tstat_d[i] = tstat_q[i];
            if (wrTstat && !ioWrData[i]) begin
                tstat_d[i] = 1'b0;
            end
            if (outNow[i] && !outPrev_q[i]) begin
                tstat_d[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            tstat_q <= TSTAT_RESET;
            outPrev_q <= 2'h0;
            timerIrq_q <= 1'b0;
        end else begin
            tstat_q <= tstat_d;
            outPrev_q <= outNow;
            timerIrq_q <= out0S || out2S;
        end
    end

    // Read path: only the timer status is readable, others return zero
    logic [7:0] rdData_q, rdData_d;
    always_comb begin
        rdData_d = rdData_q;
        if (ioRd) begin
            rdData_d = RD_UNMAPPED;
            if (ioAddr == TMR_STAT_PORT) begin
                rdData_d = {6'h00, tstat_q};
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            rdData_q <= RD_UNMAPPED;
        end else begin
            rdData_q <= rdData_d;
        end
    end

    // Outputs, each straight from a flip-flop except zeroParity, which is an inverted flip-flop
    assign ioRdData = rdData_q;
    assign memSel = memSel_q;
    assign sel16 = sel16_q;
    assign int8 = int8_q;
    assign int16 = int16_q;
    assign zeroParity = !memory_control_latch_q[ZERO_PAR_BIT];
    assign parityCheckEn = memory_control_latch_q[PAR_CHECK_BIT];
    assign parityErr = parityErr_q;
    assign chan0_tick = tick_q;
    assign chan2_tick = tick_q;
    assign chan1_tick = chan1Tick_q;
    assign timerIrq = timerIrq_q;
endmodule : scl_top

//--- rtl/scl_pkg.sv
// Constants and carrier types shared by the system control latches
package scl_pkg;
    // Port addresses on the 8-bit I/O space
    localparam logic [7:0] MEM_CTL_PORT = 8'h00FC;
    localparam logic [7:0] TMR_STAT_PORT = 8'h00FB;
    localparam logic [7:0] SWAP_PORT = 8'h00FE;

    // Processor swap latch fields
    localparam int SWAP_MASK_BIT = 0;
    localparam int SWAP_FORCE_INT_BIT = 1;
    localparam int SWAP_SEL16_BIT = 7;

    // Memory control latch fields
    localparam int RAM_MAP_LO_BIT = 0;
    localparam int RAM_MAP_HI_BIT = 1;
    localparam int ROM_OPT_LO_BIT = 2;
    localparam int ROM_OPT_HI_BIT = 3;
    localparam int ZERO_PAR_BIT = 4;
    localparam int PAR_CHECK_BIT = 5;

    // Timer status fields
    localparam int TSTAT_CHAN0_BIT = 0;
    localparam int TSTAT_CHAN2_BIT = 1;

    // Values after reset
    localparam logic [7:0] MEM_CTL_RESET = 8'h0000;
    localparam logic [7:0] SWAP_RESET = 8'h0000;
    localparam logic [1:0] TSTAT_RESET = 2'h0;
    localparam logic [7:0] RD_UNMAPPED = 8'h0000;

    // Timer tick: 250 kHz from the 40 MHz system clock
    localparam int CLOCK_HZ = 40000000;
    localparam int TIMER_TICK_HZ = 250000;
    localparam int TICK_CYCLES = CLOCK_HZ / TIMER_TICK_HZ;
    localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);

    // Memory map, in kilobytes and address fields
    localparam logic [7:0] SWAP_LEN_KB = 8'h0030;
    // Option 3 exchanges 56K blocks, not the 48K of options 1 and 2
    localparam logic [7:0] SWAP3_LEN_KB = 8'h0038;
    localparam logic [7:0] OPT1_A_KB = 8'h0000;
    localparam logic [7:0] OPT1_B_KB = 8'h0040;
    localparam logic [7:0] OPT2_A_KB = 8'h0000;
    localparam logic [7:0] OPT2_B_KB = 8'h0070;
    localparam logic [7:0] OPT3_A_KB = 8'h0004;
    localparam logic [7:0] OPT3_B_KB = 8'h0044;
    localparam logic [7:0] RAM_TOP_KB = 8'h00C0;
    localparam int ROM_WIN_BITS = 14;
    localparam logic [3:0] VRAM_FIRST_NIB = 4'hC;
    localparam logic [3:0] VRAM_LAST_NIB = 4'hE;

    // ROM addressing options
    typedef enum logic [1:0] {
        SCL_ROM_ALL = 2'h0,
        SCL_ROM_EVERY_PAGE = 2'h1,
        SCL_ROM_FIRST_MEG = 2'h2,
        SCL_ROM_OFF = 2'h3
    } scl_rom_opt_e;

    // Memory cycle from the active processor
    typedef struct packed {
        logic [23:0] addr;
        logic rd;
        logic wr;
    } scl_mem_req_s;

    // Chip selects and the remapped RAM address
    typedef struct packed {
        logic romSel;
        logic ramSel;
        logic vramSel;
        logic [17:0] ramAddr;
    } scl_mem_sel_s;
endpackage : scl_pkg

//--- rtl/scl_addr_map.sv
// Memory address decoder for ROM overlay, video RAM and RAM bank remapping
`timescale 1ns/1ps
module scl_addr_map (
    // Cycle and option selects
    input wire scl_pkg::scl_mem_req_s req,
    input wire logic [1:0] romOpt,
    input wire logic [1:0] ramMap,
    // Decoded selects
    output scl_pkg::scl_mem_sel_s sel
);
    import scl_pkg::*;

    // Exchange two equal blocks of kilobytes, leave the rest alone
    function automatic logic [7:0] swapKb(input logic [7:0] kb, input logic [7:0] a,
                                          input logic [7:0] b, input logic [7:0] len);
        logic [7:0] r;
        r = kb;
        if (kb >= a && kb < 8'(a + len)) begin
            r = 8'(kb - a + b);
        end else if (kb >= b && kb < 8'(b + len)) begin
            r = 8'(kb - b + a);
        end
        return r;
    endfunction : swapKb

    logic romHit;
    logic inFirstMeg;
    logic [7:0] kb;
    logic [7:0] mappedKb;

    // ROM overlay per option; ROM window is the top of a 64K page
    always_comb begin
        inFirstMeg = (req.addr[23:20] == 4'h0);
        romHit = 1'b0;
        case (scl_rom_opt_e'(romOpt))
            SCL_ROM_ALL: romHit = req.rd;
            SCL_ROM_EVERY_PAGE: romHit = &req.addr[15:ROM_WIN_BITS];
            SCL_ROM_FIRST_MEG: romHit = inFirstMeg && (&req.addr[19:ROM_WIN_BITS]);
            SCL_ROM_OFF: romHit = 1'b0;
            default: romHit = 1'b0;
        endcase
    end

    // RAM remap at 1K granularity over the low 192K
    always_comb begin
        kb = {2'h0, req.addr[15:10]} | {req.addr[17:16], 6'h00};
        case (ramMap)
            2'h1: mappedKb = swapKb(kb, OPT1_A_KB, OPT1_B_KB, SWAP_LEN_KB);
            2'h2: mappedKb = swapKb(kb, OPT2_A_KB, OPT2_B_KB, SWAP_LEN_KB);
            2'h3: mappedKb = swapKb(kb, OPT3_A_KB, OPT3_B_KB, SWAP3_LEN_KB);
            default: mappedKb = kb;
        endcase
    end

    // ROM hit deselects everything but video RAM, which shares its range
    always_comb begin
        sel.romSel = romHit && (req.rd || req.wr);
        sel.vramSel = inFirstMeg && (req.addr[19:16] >= VRAM_FIRST_NIB)
                      && (req.addr[19:16] <= VRAM_LAST_NIB) && (req.rd || req.wr);
        sel.ramSel = !romHit && (req.rd || req.wr) && (req.addr[23:18] == 6'h00)
                     && (kb < RAM_TOP_KB);
        sel.ramAddr = {mappedKb[7:0], req.addr[9:0]};
    end
endmodule : scl_addr_map

//--- test/scl_timer_model.sv
// Timer channel outputs that rise on a tick once armed by the bench
`timescale 1ns/1ps
module scl_timer_model (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Ticks from the block, arm requests from the bench
    input wire logic [1:0] tick,
    input wire logic [1:0] arm,
    // Channel outputs
    output logic [1:0] chanOut
);
    logic [1:0] armed_q, armed_d, out_q, out_d;
    // Outputs move only on their own tick, as a counter clocked by it would
    always_comb begin
        armed_d = armed_q | arm;
        out_d = out_q;
        for (int i = 0; i < 2; i++) begin
            if (tick[i]) begin
                out_d[i] = armed_q[i];
                armed_d[i] = arm[i];
            end
        end
    end
    // Registers; high for one whole tick period, then low again
    always_ff @(posedge clock) begin
        armed_q <= reset ? 2'h0 : armed_d;
        out_q <= reset ? 2'h0 : out_d;
    end
    assign chanOut = out_q;
endmodule : scl_timer_model

//--- test/scl_properties.sv
// Concurrent checks on the system control latch ports
`timescale 1ns/1ps
module scl_properties (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Watched ports
    input wire logic [7:0] ioAddr,
    input wire logic ioWr,
    input wire logic ioRd,
    input wire logic [7:0] ioWrData,
    input wire logic [7:0] ioRdData,
    input wire scl_pkg::scl_mem_req_s memReq,
    input wire scl_pkg::scl_mem_sel_s memSel,
    input wire logic sel16,
    input wire logic zeroParity,
    input wire logic parityCheckEn,
    input wire logic chan0_output,
    input wire logic chan2_output,
    input wire logic chan0_tick,
    input wire logic chan1_tick,
    input wire logic timerIrq
);
    import scl_pkg::*;
    logic [1:0] romOpt_q, romOpt_d;
    logic [8:0] gap_q, gap_d;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // Shadow ROM option; gap stays 0 until the first tick, which has no reference
    always_comb begin
        romOpt_d = romOpt_q;
        if (ioWr && ioAddr == MEM_CTL_PORT) begin
            romOpt_d = ioWrData[3:2];
        end
        gap_d = chan0_tick ? 9'h1 : (gap_q == 9'h0 ? 9'h0 : gap_q + 9'h1);
    end
    always_ff @(posedge clock) begin
        romOpt_q <= reset ? 2'h0 : romOpt_d;
        gap_q <= reset ? 9'h0 : gap_d;
    end
    swap_select_a:
        assert property (ioWr && ioAddr == SWAP_PORT |=> sel16 == $past(ioWrData[7]))
        else $error("processor select not taken from the write");
    zero_parity_a:
        assert property (ioWr && ioAddr == MEM_CTL_PORT |=> zeroParity == !$past(ioWrData[4]))
        else $error("zero parity control wrong");
    parity_enable_a:
        assert property (ioWr && ioAddr == MEM_CTL_PORT |=> parityCheckEn == $past(ioWrData[5]))
        else $error("parity check enable wrong");
    tick_gap_a:
        assert property (chan0_tick && gap_q != 9'h0 |-> gap_q == TICK_CYCLES)
        else $error("channel tick spacing wrong");
    chan1_follow_a:
        assert property (chan1_tick == $past(chan0_output, 3))
        else $error("cascaded tick does not follow channel 0 output");
    timer_irq_a:
        assert property (timerIrq == $past(chan0_output | chan2_output, 3))
        else $error("timer interrupt is not the OR of the outputs");
    read_idle_a:
        assert property (ioRd && ioAddr != TMR_STAT_PORT |=> ioRdData == RD_UNMAPPED)
        else $error("unmapped read returned data");
    read_pad_a:
        assert property (ioRd |=> ioRdData[7:2] == 6'h0)
        else $error("upper read bits not zero");
    rom_all_a:
        assert property (romOpt_q == 2'h0 && romOpt_d == 2'h0 && memReq.rd |=> memSel.romSel)
        else $error("read in option 0 missed the ROM");
    rom_off_a:
        assert property (romOpt_q == 2'h3 && romOpt_d == 2'h3 |=> !memSel.romSel)
        else $error("ROM selected in option 3");
    rom_excl_a:
        assert property (memSel.romSel |-> !memSel.ramSel)
        else $error("RAM selected beside the ROM");
endmodule : scl_properties
bind scl_top scl_properties u_scl_properties (.clock, .reset, .ioAddr, .ioWr, .ioRd,
    .ioWrData, .ioRdData, .memReq, .memSel, .sel16, .zeroParity, .parityCheckEn,
    .chan0_output, .chan2_output, .chan0_tick, .chan1_tick, .timerIrq);

//--- test/tb.sv
// Testbench for the system control latches
`timescale 1ns/1ps
module tb;
    import scl_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic ioWr = 1'b0, ioRd = 1'b0, irqReq = 1'b0, parityErrIn = 1'b0, seen;
    logic [7:0] ioAddr = 8'h00, ioWrData = 8'h00, ioRdData, rd;
    scl_mem_req_s memReq = '0;
    scl_mem_sel_s memSel;
    logic sel16, int8, int16, zeroParity, parityCheckEn, parityErr, timerIrq;
    logic chan0_tick, chan1_tick, chan2_tick;
    logic [1:0] chanOut, arm = 2'h0;
    int err_total = 0, num_checks = 0, cyc = 0, n;
    int kbs[12] = '{0, 59, 47, 48, 64, 111, 112, 159, 4, 60, 68, 124};
    always #12.5 clock = ~clock;
    scl_top u_scl_top (.clock, .reset, .ioAddr, .ioWr, .ioRd, .ioWrData, .ioRdData,
        .memReq, .memSel, .irqReq, .sel16, .int8, .int16, .parityErrIn, .zeroParity,
        .parityCheckEn, .parityErr, .chan0_output(chanOut[0]), .chan2_output(chanOut[1]),
        .chan0_tick, .chan1_tick, .chan2_tick, .timerIrq);
    scl_timer_model u_scl_timer_model (.clock, .reset, .tick({chan2_tick, chan0_tick}),
        .arm, .chanOut);
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results
    task automatic cmp(input string what, input logic [17:0] exp, input logic [17:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    // Bus cycles start and end on a rising edge, so strobes never double up
    task automatic ioWrite(input logic [7:0] a, input logic [7:0] d);
        ioAddr <= a;
        ioWrData <= d;
        ioWr <= 1'b1;
        @(posedge clock);
        ioWr <= 1'b0;
        @(posedge clock);
    endtask : ioWrite
    task automatic ioRead(input logic [7:0] a, output logic [7:0] d);
        ioAddr <= a;
        ioRd <= 1'b1;
        @(posedge clock);
        ioRd <= 1'b0;
        @(posedge clock);
        d = ioRdData;
    endtask : ioRead
    // Selects as {rom, ram, vram}; RAM address compared only when RAM is selected
    task automatic memChk(input logic [23:0] a, input logic w, input logic [2:0] s,
        input logic [17:0] ra);
        memReq <= '{addr: a, rd: !w, wr: w};
        repeat (2) @(posedge clock);
        cmp("memSel selects", 18'(s), 18'({memSel.romSel, memSel.ramSel, memSel.vramSel}));
        if (s[1]) cmp("ramAddr", ra, memSel.ramAddr);
    endtask : memChk
    task automatic waitOut(input int i, input logic v);
        while (chanOut[i] !== v) @(posedge clock);
        repeat (5) @(posedge clock);
    endtask : waitOut
    task automatic pulseErr;
        parityErrIn <= 1'b1;
        repeat (4) @(posedge clock);
        parityErrIn <= 1'b0;
        repeat (4) @(posedge clock);
    endtask : pulseErr
    task automatic watch(input logic which);
        seen = 1'b0;
        repeat (5) begin
            @(posedge clock);
            seen |= which ? int16 : int8;
        end
    endtask : watch
    // Expected kilobyte index after the RAM bank exchange
    function automatic int expKb(input int m, input int k);
        if (m == 1 && k < 48) return k + 64;
        if (m == 1 && k >= 64 && k < 112) return k - 64;
        if (m == 2 && k < 48) return k + 112;
        if (m == 2 && k >= 112 && k < 160) return k - 112;
        if (m == 3 && k >= 4 && k < 60) return k + 64;
        if (m == 3 && k >= 68 && k < 124) return k - 64;
        return k;
    endfunction : expKb
    // Hang guard, well above the roughly 1200 cycles the tests need
    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            results();
        end
    end
    initial begin
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        cmp("sel16", 18'h0, 18'(sel16));
        cmp("zeroParity", 18'h1, 18'(zeroParity));
        ioRead(TMR_STAT_PORT, rd);
        cmp("status", 18'h0, 18'(rd));
        ioRead(8'hFD, rd);
        cmp("unmapped read", 18'h0, 18'(rd));
        memChk(24'h01_2345, 1'b0, 3'b100, 18'h0);
        memChk(24'h01_2345, 1'b1, 3'b010, 18'h1_2345);
        memChk(24'h0C_0010, 1'b0, 3'b101, 18'h0);
        for (int o = 0; o < 4; o++) begin
            ioWrite(MEM_CTL_PORT, 8'(o << 2));
            memChk(24'h01_C155, 1'b0, {o < 2, o >= 2, 1'b0}, 18'h1_C155);
            memChk(24'h0F_C000, 1'b0, {o != 3, 2'b00}, 18'h0);
        end
        for (int m = 0; m < 4; m++) begin
            ioWrite(MEM_CTL_PORT, 8'h0C | 8'(m));
            foreach (kbs[j]) memChk(24'(kbs[j] << 10) | 24'h0155, 1'b0, 3'b010,
                18'(expKb(m, kbs[j]) << 10) | 18'h0155);
        end
        $display("memory map test done");
        ioWrite(SWAP_PORT, 8'h80);
        cmp("sel16", 18'h1, 18'(sel16));
        ioWrite(8'hFD, 8'h00);
        cmp("sel16", 18'h1, 18'(sel16));
        ioWrite(SWAP_PORT, 8'h7C);
        cmp("sel16", 18'h0, 18'(sel16));
        ioWrite(SWAP_PORT, 8'h82);
        watch(1'b1);
        cmp("forced int16", 18'h1, 18'(seen));
        ioWrite(SWAP_PORT, 8'h00);
        watch(1'b0);
        cmp("resume int8", 18'h0, 18'(seen));
        irqReq <= 1'b1;
        repeat (6) @(posedge clock);
        cmp("int8 routed", 18'h1, 18'({int16, int8}));
        irqReq <= 1'b0;
        repeat (6) @(posedge clock);
        ioWrite(SWAP_PORT, 8'h01);
        irqReq <= 1'b1;
        repeat (6) @(posedge clock);
        cmp("masked routing", 18'h6, 18'({sel16, int16, int8}));
        irqReq <= 1'b0;
        repeat (6) @(posedge clock);
        ioWrite(SWAP_PORT, 8'h00);
        $display("swap test done");
        pulseErr();
        cmp("parityErr off", 18'h0, 18'(parityErr));
        ioWrite(MEM_CTL_PORT, 8'h30);
        cmp("parity ctl", 18'h1, 18'({zeroParity, parityCheckEn}));
        pulseErr();
        ioWrite(MEM_CTL_PORT, 8'h30);
        cmp("parityErr held", 18'h1, 18'(parityErr));
        ioWrite(MEM_CTL_PORT, 8'h10);
        ioWrite(MEM_CTL_PORT, 8'h30);
        cmp("parityErr cleared", 18'h0, 18'(parityErr));
        $display("parity test done");
        while (chan0_tick !== 1'b1) @(posedge clock);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (chan0_tick !== 1'b1);
        cmp("tick gap", 18'(TICK_CYCLES), 18'(n));
        cmp("chan2_tick", 18'h1, 18'(chan2_tick));
        arm <= 2'h1;
        @(posedge clock);
        arm <= 2'h0;
        waitOut(0, 1'b1);
        cmp("timerIrq", 18'h1, 18'(timerIrq));
        waitOut(0, 1'b0);
        ioRead(TMR_STAT_PORT, rd);
        cmp("status held", 18'h1, 18'({timerIrq, rd}));
        arm <= 2'h2;
        @(posedge clock);
        arm <= 2'h0;
        waitOut(1, 1'b1);
        waitOut(1, 1'b0);
        ioRead(TMR_STAT_PORT, rd);
        cmp("status both", 18'h3, 18'(rd));
        ioWrite(TMR_STAT_PORT, 8'h02);
        ioRead(TMR_STAT_PORT, rd);
        cmp("status clear 0", 18'h2, 18'(rd));
        ioWrite(TMR_STAT_PORT, 8'h01);
        ioRead(TMR_STAT_PORT, rd);
        cmp("status clear 1", 18'h0, 18'(rd));
        $display("timer test done");
        results();
    end
endmodule : tb
